/* File: shared/cgcs_pkg.sv */
// Package of constants and types for the clock generator control pins
package cgcs_pkg;

   // ------------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------------
   localparam int CGCS_NUM_OUTPUTS = 10;  // Clock outputs driven
   localparam int CGCS_STEP_W      = 16;  // Width of step and offset
   localparam int CGCS_OSEL_W      = 4;   // Width of stepped-output index
   localparam int CGCS_REF_W       = 2;   // Width of reference select
   localparam int CGCS_STAT_W      = 4;   // Width of watched status vector
   localparam int CGCS_SYNC_STAGES = 2;   // Synchroniser depth

   // ------------------------------------------------------------------
   // Status vector field positions
   // ------------------------------------------------------------------
   localparam int CGCS_STAT_LOCK_POS = 0;  // PLL lock bit
   localparam int CGCS_STAT_LOSS_POS = 1;  // Crystal loss bit
   localparam int CGCS_STAT_REF_POS  = 2;  // Active reference, two bits

   // ------------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------------
   localparam logic [CGCS_STEP_W-1:0] CGCS_OFFSET_RST = 16'h0000;
   localparam logic [CGCS_REF_W-1:0]  CGCS_REF_RST    = 2'h0;
   localparam logic                   CGCS_IRQ_N_RST  = 1'h1;

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef logic [CGCS_STEP_W-1:0] cgcs_step_t;   // Step or offset word
   typedef logic [CGCS_REF_W-1:0]  cgcs_ref_t;    // Reference index
   typedef logic [CGCS_OSEL_W-1:0] cgcs_osel_t;   // Output index

   // Serial port personality
   typedef enum logic {
      CGCS_PORT_SPI,
      CGCS_PORT_I2C
   } cgcs_port_e;

endpackage : cgcs_pkg

/* File: shared/cgcs_step_if.sv */
// Interface carrying frequency step events between control modules
`timescale 1ns/10ps
interface cgcs_step_if;
   logic up_pulse;    // One-cycle step-up event
   logic down_pulse;  // One-cycle step-down event

   // Producer side: edge detector
   modport src (output up_pulse, output down_pulse);
   // Consumer side: offset accumulators
   modport dst (input up_pulse, input down_pulse);
endinterface : cgcs_step_if

/* File: src/cgcs_edge_sync.sv */
// Synchronisers and rising-edge detectors for the step pins
`timescale 1ns/10ps
module cgcs_edge_sync
   import cgcs_pkg::*;
(
   input  wire logic mclk_in,          // Core clock
   input  wire logic rst_in,           // Synchronous reset
   input  wire logic freq_step_up_in,  // Raw step-up pin
   input  wire logic freq_step_down_in,// Raw step-down pin
   cgcs_step_if.src  step_out          // Step event pulses
);

   // ------------------------------------------------------------------
   // Synchroniser chains
   // ------------------------------------------------------------------
   logic [CGCS_SYNC_STAGES-1:0] up_sync_reg;    // Step-up chain
   logic [CGCS_SYNC_STAGES-1:0] down_sync_reg;  // Step-down chain
   logic                        up_last_reg;    // Previous settled up
   logic                        down_last_reg;  // Previous settled down

   // Shift pins in; only the last stage is looked at
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         up_sync_reg   <= '0;
         down_sync_reg <= '0;
         up_last_reg   <= 1'h0;
         down_last_reg <= 1'h0;
      end else begin
         up_sync_reg   <= {up_sync_reg[CGCS_SYNC_STAGES-2:0],
                           freq_step_up_in};
         down_sync_reg <= {down_sync_reg[CGCS_SYNC_STAGES-2:0],
                           freq_step_down_in};
         up_last_reg   <= up_sync_reg[CGCS_SYNC_STAGES-1];
         down_last_reg <= down_sync_reg[CGCS_SYNC_STAGES-1];
      end
   end

   // ------------------------------------------------------------------
   // Edge detection: one pulse per assertion
   // ------------------------------------------------------------------
   assign step_out.up_pulse   = up_sync_reg[CGCS_SYNC_STAGES-1]
                                & ~up_last_reg;
   assign step_out.down_pulse = down_sync_reg[CGCS_SYNC_STAGES-1]
                                & ~down_last_reg;

endmodule // cgcs_edge_sync

/* File: src/cgcs_status_watch.sv */
// Status change detector with sticky change flag
`timescale 1ns/10ps
module cgcs_status_watch
   import cgcs_pkg::*;
#(
   parameter int WIDTH = CGCS_STAT_W  // Watched vector width
)(
   input  wire logic             mclk_in,     // Core clock
   input  wire logic             rst_in,      // Synchronous reset
   input  wire logic [WIDTH-1:0] status_in,   // Watched status
   input  wire logic             clear_in,    // Clear sticky flag
   output logic                  changed_out  // Sticky change flag
);

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   logic [WIDTH-1:0] prev_reg;     // Status seen last cycle
   logic             primed_reg;   // Prev holds a real sample
   logic             changed_reg;  // Sticky flag
   wire              edge_seen;    // Any bit moved this cycle

   // Difference against the last sample, only once primed
   assign edge_seen = primed_reg & (|(prev_reg ^ status_in));

   // Track status; a change beats a same-cycle clear
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         prev_reg    <= '0;
         primed_reg  <= 1'h0;
         changed_reg <= 1'h0;
      end else begin
         prev_reg    <= status_in;
         primed_reg  <= 1'h1;
         if (edge_seen) begin
            changed_reg <= 1'h1;  // Set wins
         end else if (clear_in) begin
            changed_reg <= 1'h0;
         end
      end
   end

   assign changed_out = changed_reg;

endmodule // cgcs_status_watch

/* File: src/cgcs_ctrl.sv */
// Control and status pin logic of a multi-output clock generator
`timescale 1ns/10ps
module cgcs_ctrl
   import cgcs_pkg::*;
#(
   parameter int NUM_OUTPUTS = CGCS_NUM_OUTPUTS,  // Clock outputs
   parameter int STEP_W      = CGCS_STEP_W        // Step word width
)(
   // Clock and reset
   input  wire logic                 mclk_in,
   input  wire logic                 rst_in,
   input  wire logic                 device_reset_n_in,
   // Serial port personality pins
   input  wire logic                 i2c_select_in,
   input  wire logic                 addr_low_or_chip_select_n_in,
   output logic                      i2c_addr_bit0_out,
   output logic                      spi_chip_select_out,
   output cgcs_pkg::cgcs_port_e      port_mode_out,
   // Output enable and alignment pins
   input  wire logic                 output_disable_pin_in,
   input  wire logic                 output_divider_align_n_in,
   input  wire logic [NUM_OUTPUTS-1:0] output_enable_cfg_in,
   output logic [NUM_OUTPUTS-1:0]    clock_output_enable_out,
   output logic                      divider_reset_out,
   // Frequency stepping
   input  wire logic                 freq_step_up_in,
   input  wire logic                 freq_step_down_in,
   input  wire cgcs_pkg::cgcs_osel_t step_output_sel_in,
   input  wire logic [STEP_W-1:0]    step_size_in,
   output logic [NUM_OUTPUTS-1:0][STEP_W-1:0] freq_offset_out,
   output logic                      freq_step_done_out,
   // Reference selection
   input  wire logic                 manual_ref_mode_in,
   input  wire logic                 in_select0_in,
   input  wire logic                 in_select1_in,
   input  wire cgcs_pkg::cgcs_ref_t  auto_ref_sel_in,
   output cgcs_pkg::cgcs_ref_t       active_ref_out,
   // Status from the analog core
   input  wire logic                 pll_locked_in,
   input  wire logic                 crystal_signal_valid_in,
   input  wire logic                 irq_clear_in,
   // Status pins
   output logic                      pll_lock_indicator_out,
   output logic                      crystal_signal_loss_indicator_out,
   output logic                      status_change_irq_n_out
);

   // ------------------------------------------------------------------
   // Reset combination
   // ------------------------------------------------------------------
   // Core reset or reset pin low; both sampled on the clock
   wire core_reset;  // Combined synchronous reset

   assign core_reset = rst_in | ~device_reset_n_in;

   // ------------------------------------------------------------------
   // Serial port personality decode
   // ------------------------------------------------------------------
   wire         i2c_mode;        // Port runs as I2C
   wire         addr_bit_next;   // Address bit in I2C mode
   wire         chip_sel_next;   // Active-high select in SPI mode
   cgcs_port_e  port_mode_next;  // Personality for the port engine

   assign i2c_mode       = i2c_select_in;
   assign port_mode_next = i2c_mode ? CGCS_PORT_I2C
                                    : CGCS_PORT_SPI;
   // Bit zero in SPI mode, select off in I2C mode
   assign addr_bit_next  = i2c_mode & addr_low_or_chip_select_n_in;
   assign chip_sel_next  = ~i2c_mode & ~addr_low_or_chip_select_n_in;

   logic        addr_bit_reg;   // Registered address bit
   logic        chip_sel_reg;   // Registered chip select
   cgcs_port_e  port_mode_reg;  // Registered personality

   // Register the personality outputs
   always_ff @(posedge mclk_in) begin
      if (core_reset) begin
         addr_bit_reg  <= 1'h0;
         chip_sel_reg  <= 1'h0;
         port_mode_reg <= CGCS_PORT_I2C;
      end else begin
         addr_bit_reg  <= addr_bit_next;
         chip_sel_reg  <= chip_sel_next;
         port_mode_reg <= port_mode_next;
      end
   end

   assign i2c_addr_bit0_out   = addr_bit_reg;
   assign spi_chip_select_out = chip_sel_reg;
   assign port_mode_out       = port_mode_reg;

   // ------------------------------------------------------------------
   // Clock output enables
   // ------------------------------------------------------------------
   // Run out of reset, disable pin low, per-output enable set
   wire [NUM_OUTPUTS-1:0] enable_next;  // Next enable per output

   assign enable_next = (core_reset | output_disable_pin_in)
                        ? '0 : output_enable_cfg_in;

   logic [NUM_OUTPUTS-1:0] enable_reg;  // Registered enables

   // Enables forced off while in reset
   always_ff @(posedge mclk_in) begin
      if (core_reset) begin
         enable_reg <= '0;
      end else begin
         enable_reg <= enable_next;
      end
   end

   assign clock_output_enable_out = enable_reg;

   // ------------------------------------------------------------------
   // Output divider alignment
   // ------------------------------------------------------------------
   // Align pin low or reset holds dividers, so they restart aligned
   wire divider_reset_next;  // Hold dividers in reset

   assign divider_reset_next = ~output_divider_align_n_in;

   logic divider_reset_reg;  // Registered divider reset

   // Divider reset follows the align pin
   always_ff @(posedge mclk_in) begin
      if (core_reset) begin
         divider_reset_reg <= 1'h1;
      end else begin
         divider_reset_reg <= divider_reset_next;
      end
   end

   assign divider_reset_out = divider_reset_reg;

   // ------------------------------------------------------------------
   // Step pin synchronisation
   // ------------------------------------------------------------------
   cgcs_step_if step_bus ();  // Step events to the accumulators

   // Sync and edge-detect step pins
   cgcs_edge_sync u_edge_sync (
      .mclk_in           (mclk_in),
      .rst_in            (core_reset),
      .freq_step_up_in   (freq_step_up_in),
      .freq_step_down_in (freq_step_down_in),
      .step_out          (step_bus.src)
   );

   // ------------------------------------------------------------------
   // Frequency offset accumulators
   // ------------------------------------------------------------------
   // Wrapping offset per output; up and down together cancel
   wire step_up;    // Step-up event
   wire step_down;  // Step-down event
   wire step_any;   // Exactly one direction stepped

   assign step_up   = step_bus.up_pulse;
   assign step_down = step_bus.down_pulse;
   assign step_any  = step_up ^ step_down;

   logic [NUM_OUTPUTS-1:0][STEP_W-1:0] offset_reg;  // Offsets

   // One accumulator per output
   genvar gi;
   generate
      for (gi = 0; gi < NUM_OUTPUTS; gi++) begin : g_offset
         wire               hit;       // This output is the target
         wire [STEP_W-1:0]  up_val;    // Offset plus one step
         wire [STEP_W-1:0]  down_val;  // Offset minus one step
         wire [STEP_W-1:0]  offset_next;

         assign hit      = (step_output_sel_in
                            == CGCS_OSEL_W'(gi));
         assign up_val   = STEP_W'(offset_reg[gi] + step_size_in);
         assign down_val = STEP_W'(offset_reg[gi] - step_size_in);
         assign offset_next = !(hit && step_any) ? offset_reg[gi]
                              : step_up ? up_val
                              : down_val;

         // Offset returns to its default in reset
         always_ff @(posedge mclk_in) begin
            if (core_reset) begin
               offset_reg[gi] <= STEP_W'(CGCS_OFFSET_RST);
            end else begin
               offset_reg[gi] <= offset_next;
            end
         end
      end
   endgenerate

   assign freq_offset_out = offset_reg;

   // ------------------------------------------------------------------
   // Step completion strobe
   // ------------------------------------------------------------------
   wire step_valid;  // Step hit an existing output

   assign step_valid = step_any
                       && (32'(step_output_sel_in) < NUM_OUTPUTS);

   logic step_done_reg;  // Pulse on the edge the offset updates, one cycle after a step event

   // Strobe a step that changed an offset
   always_ff @(posedge mclk_in) begin
      if (core_reset) begin
         step_done_reg <= 1'h0;
      end else begin
         step_done_reg <= step_valid;
      end
   end

   assign freq_step_done_out = step_done_reg;

   // ------------------------------------------------------------------
   // Reference selection
   // ------------------------------------------------------------------
   // Pins pick the reference in manual mode, else configuration
   wire [CGCS_REF_W-1:0] pin_ref;   // Reference from pins
   wire [CGCS_REF_W-1:0] ref_next;  // Chosen reference

   assign pin_ref  = {in_select1_in, in_select0_in};
   assign ref_next = manual_ref_mode_in ? pin_ref
                                        : auto_ref_sel_in;

   logic [CGCS_REF_W-1:0] ref_reg;  // Registered reference

   // Reference returns to its default in reset
   always_ff @(posedge mclk_in) begin
      if (core_reset) begin
         ref_reg <= CGCS_REF_RST;
      end else begin
         ref_reg <= ref_next;
      end
   end

   assign active_ref_out = ref_reg;

   // ------------------------------------------------------------------
   // Status indicators
   // ------------------------------------------------------------------
   logic lock_reg;  // Lock indicator, high when locked
   logic loss_reg;  // Crystal loss indicator, high on loss

   // Indicators follow status; unlocked in reset
   always_ff @(posedge mclk_in) begin
      if (core_reset) begin
         lock_reg <= 1'h0;
         loss_reg <= 1'h0;
      end else begin
         lock_reg <= pll_locked_in;
         loss_reg <= ~crystal_signal_valid_in;
      end
   end

   assign pll_lock_indicator_out            = lock_reg;
   assign crystal_signal_loss_indicator_out = loss_reg;

   // ------------------------------------------------------------------
   // Status change interrupt
   // ------------------------------------------------------------------
   // Lock, loss or reference movement latches a flag: pin low
   wire [CGCS_STAT_W-1:0] status_vec;  // Watched status
   wire                   changed;     // Sticky change flag

   assign status_vec[CGCS_STAT_LOCK_POS] = lock_reg;
   assign status_vec[CGCS_STAT_LOSS_POS] = loss_reg;
   assign status_vec[CGCS_STAT_REF_POS +: CGCS_REF_W] = ref_reg;

   // Change detector with set-over-clear
   cgcs_status_watch #(
      .WIDTH (CGCS_STAT_W)
   ) u_status_watch (
      .mclk_in     (mclk_in),
      .rst_in      (core_reset),
      .status_in   (status_vec),
      .clear_in    (irq_clear_in),
      .changed_out (changed)
   );

   logic irq_n_reg;  // Interrupt pin level

   // Drive the pin low while a change is pending
   always_ff @(posedge mclk_in) begin
      if (core_reset) begin
         irq_n_reg <= CGCS_IRQ_N_RST;
      end else begin
         irq_n_reg <= ~changed;
      end
   end

   assign status_change_irq_n_out = irq_n_reg;

endmodule // cgcs_ctrl

/* File: test/cgcs_ctrl_sva.sv */
// Concurrent checks on the ports of the control pin block
`timescale 1ns/10ps
module cgcs_ctrl_sva
   import cgcs_pkg::*;
#(
   parameter int NUM_OUTPUTS = CGCS_NUM_OUTPUTS  // Clock outputs
)(
   input logic                   mclk_in,
   input logic                   rst_in,
   input logic                   device_reset_n_in,
   input logic                   i2c_select_in,
   input logic                   addr_low_or_chip_select_n_in,
   input logic                   spi_chip_select_out,
   input cgcs_pkg::cgcs_port_e   port_mode_out,
   input logic                   output_disable_pin_in,
   input logic [NUM_OUTPUTS-1:0] clock_output_enable_out,
   input logic                   output_divider_align_n_in,
   input logic                   divider_reset_out,
   input logic                   freq_step_up_in,
   input logic                   freq_step_down_in,
   input cgcs_pkg::cgcs_osel_t   step_output_sel_in,
   input logic                   freq_step_done_out,
   input logic                   pll_locked_in,
   input logic                   pll_lock_indicator_out,
   input logic                   status_change_irq_n_out
);
   // -------------------------------------------------------------
   // Clocking and reset
   // -------------------------------------------------------------
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (rst_in || !device_reset_n_in);

   chk_spi_select: assert property (
      !i2c_select_in |=>
      spi_chip_select_out == !$past(addr_low_or_chip_select_n_in))
      else $error("bad chip select");
   chk_port_mode: assert property (
      1'b1 |=> (port_mode_out == CGCS_PORT_I2C) == $past(i2c_select_in))
      else $error("bad port mode");
   chk_reset_state: assert property (disable iff (1'b0)
      (rst_in || !device_reset_n_in) |=> clock_output_enable_out == '0
      && divider_reset_out && status_change_irq_n_out)
      else $error("bad reset state");
   chk_out_disable: assert property (
      output_disable_pin_in |=> clock_output_enable_out == '0)
      else $error("outputs not disabled");
   chk_lock_follow: assert property (
      1'b1 |=> pll_lock_indicator_out == $past(pll_locked_in))
      else $error("bad lock indicator");
   chk_align_reset: assert property (
      1'b1 |=> divider_reset_out == !$past(output_divider_align_n_in))
      else $error("bad divider reset");
   chk_irq_on_change: assert property (
      $changed(pll_lock_indicator_out) && !$past(rst_in) &&
      $past(device_reset_n_in) && !$past(rst_in, 2) &&
      $past(device_reset_n_in, 2) |-> ##2 !status_change_irq_n_out)
      else $error("interrupt missing");
   chk_one_step: assert property (
      $rose(freq_step_up_in) && !freq_step_down_in &&
      step_output_sel_in < NUM_OUTPUTS |->
      ##3 freq_step_done_out ##1 !freq_step_done_out)
      else $error("bad step done pulse");
endmodule // cgcs_ctrl_sva

bind cgcs_ctrl cgcs_ctrl_sva #(.NUM_OUTPUTS(NUM_OUTPUTS)) cgcs_ctrl_sva_i (
   .mclk_in, .rst_in, .device_reset_n_in, .i2c_select_in,
   .addr_low_or_chip_select_n_in, .spi_chip_select_out, .port_mode_out,
   .output_disable_pin_in, .clock_output_enable_out,
   .output_divider_align_n_in, .divider_reset_out, .freq_step_up_in,
   .freq_step_down_in, .step_output_sel_in, .freq_step_done_out,
   .pll_locked_in, .pll_lock_indicator_out, .status_change_irq_n_out);

/* File: test/cgcs_host_model.sv */
// Host controller model driving the control pins of the block
`timescale 1ns/10ps
module cgcs_host_model (
   input  wire logic mclk_in,             // Core clock
   output logic      soft_reset_out,      // Soft reset request
   output logic      device_reset_n_out,  // Device reset pin
   output logic      i2c_select_out,      // Port personality pin
   output logic      addr_cs_n_out,       // Shared address or select
   output logic      disable_out,         // Output disable pin
   output logic      align_n_out,         // Divider align pin
   output logic      step_up_out,         // Step-up pin
   output logic      step_down_out        // Step-down pin
);
   // Wait edges, then settle just past the last one
   task automatic tick(input int n);
      repeat (n) @(posedge mclk_in);
      #1;
   endtask
   // Level pins: reset, personality, select, disable, align
   task automatic set_pins(input logic [4:0] p);
      {device_reset_n_out, i2c_select_out, addr_cs_n_out, disable_out,
       align_n_out} = p;
   endtask
   // One assertion, high and low long enough for the synchroniser
   task automatic step(input logic up, input logic down);
      {step_up_out, step_down_out} = {up, down};
      tick(3);
      {step_up_out, step_down_out} = 2'b00;
      tick(3);
   endtask
   // Align pin plus soft reset for a tight realignment
   task automatic realign();
      align_n_out = 1'b0;
      soft_reset_out = 1'b1;
      tick(2);
      align_n_out = 1'b1;
      soft_reset_out = 1'b0;
   endtask
   // Power-up: reset held for two edges
   initial begin
      soft_reset_out = 1'b1;
      {step_up_out, step_down_out} = 2'b00;
      set_pins(5'b11101);
      tick(2);
      soft_reset_out = 1'b0;
   end
endmodule // cgcs_host_model

/* File: test/cgcs_ctrl_tb.sv */
// Self-checking testbench of the clock generator control pins
`timescale 1ns/10ps
module cgcs_ctrl_tb;
   import cgcs_pkg::*;
   // -------------------------------------------------------------
   // Signals
   // -------------------------------------------------------------
   logic        mclk_in, rst_in, device_reset_n_in, i2c_select_in;
   logic        addr_low_or_chip_select_n_in, output_disable_pin_in;
   logic        output_divider_align_n_in, divider_reset_out;
   logic        freq_step_up_in, freq_step_down_in, freq_step_done_out;
   logic        manual_ref_mode_in, in_select0_in, in_select1_in;
   logic        pll_locked_in, crystal_signal_valid_in, irq_clear_in;
   logic        i2c_addr_bit0_out, spi_chip_select_out;
   logic        pll_lock_indicator_out, crystal_signal_loss_indicator_out;
   logic        status_change_irq_n_out;
   logic [9:0]  output_enable_cfg_in, clock_output_enable_out;
   logic [15:0] step_size_in;
   cgcs_osel_t  step_output_sel_in;
   cgcs_ref_t   auto_ref_sel_in, active_ref_out;
   cgcs_port_e  port_mode_out;
   logic [CGCS_NUM_OUTPUTS-1:0][15:0] freq_offset_out;
   int          fails = 0, total_checks = 0, done_cnt = 0;

   cgcs_host_model cgcs_host_model_i (
      .mclk_in, .soft_reset_out(rst_in),
      .device_reset_n_out(device_reset_n_in), .i2c_select_out(i2c_select_in),
      .addr_cs_n_out(addr_low_or_chip_select_n_in),
      .disable_out(output_disable_pin_in),
      .align_n_out(output_divider_align_n_in),
      .step_up_out(freq_step_up_in), .step_down_out(freq_step_down_in));

   cgcs_ctrl cgcs_ctrl_i (.*);

   // -------------------------------------------------------------
   // Clock and done-pulse counter
   // -------------------------------------------------------------
   initial begin
      mclk_in = 1'b0;
      forever #5 mclk_in = ~mclk_in;
   end
   // Counts cycles with done high
   always @(negedge mclk_in) begin
      if (freq_step_done_out === 1'b1) done_cnt++;
   end

   // -------------------------------------------------------------
   // Tasks
   // -------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge mclk_in);
      #1;
   endtask
   // Compare one word
   task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Compare one flag
   task automatic check_bit(input logic got, input logic exp);
      check_word({15'h0000, got}, {15'h0000, exp});
   endtask
   // Fixed values while reset is active
   task automatic check_reset();
      check_word({6'h00, clock_output_enable_out}, 16'h0000);
      check_bit(divider_reset_out, 1'b1);
      check_bit(status_change_irq_n_out, 1'b1);
      check_word(freq_offset_out[9], 16'h0000);
   endtask
   // One pin assertion and the count of steps it gave
   task automatic do_step(input logic u, input logic d, input int n);
      int c;
      c = done_cnt;
      cgcs_host_model_i.step(u, d);
      check_word(16'(done_cnt - c), 16'(n));
   endtask
   // Print counts and verdict, then stop
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      output_enable_cfg_in = 10'h2A5;
      step_output_sel_in = 4'h3;
      step_size_in = 16'h0100;
      {manual_ref_mode_in, in_select1_in, in_select0_in} = 3'h0;
      auto_ref_sel_in = 2'h0;
      pll_locked_in = 1'b0;
      crystal_signal_valid_in = 1'b1;
      irq_clear_in = 1'b0;
      tick(1);
      check_reset();
      tick(2);
      // Personality for every select and shared pin level
      for (int i = 0; i < 4; i++) begin
         cgcs_host_model_i.set_pins({1'b1, i[1], i[0], 2'b01});
         tick(1);
         check_bit(i2c_addr_bit0_out, i[1] & i[0]);
         check_bit(spi_chip_select_out, !i[1] & !i[0]);
         check_bit(port_mode_out == CGCS_PORT_I2C, i[1]);
      end
      // Output disable and divider alignment
      tick(1);
      check_word({6'h00, clock_output_enable_out}, 16'h02A5);
      cgcs_host_model_i.set_pins(5'b11110);
      tick(1);
      check_word({6'h00, clock_output_enable_out}, 16'h0000);
      check_bit(divider_reset_out, 1'b1);
      cgcs_host_model_i.set_pins(5'b11101);
      tick(1);
      check_bit(divider_reset_out, 1'b0);
      // Status indicators and interrupt set then clear
      {pll_locked_in, crystal_signal_valid_in} = 2'b10;
      tick(1);
      check_bit(pll_lock_indicator_out, 1'b1);
      check_bit(crystal_signal_loss_indicator_out, 1'b1);
      tick(2);
      check_bit(status_change_irq_n_out, 1'b0);
      irq_clear_in = 1'b1;
      tick(1);
      irq_clear_in = 1'b0;
      tick(2);
      check_bit(status_change_irq_n_out, 1'b1);
      // Reference from pins in manual mode, else automatic
      {manual_ref_mode_in, in_select1_in, in_select0_in} = 3'b110;
      auto_ref_sel_in = 2'h3;
      tick(1);
      check_word({14'h0000, active_ref_out}, 16'h0002);
      manual_ref_mode_in = 1'b0;
      tick(1);
      check_word({14'h0000, active_ref_out}, 16'h0003);
      // Steps: up, two downs with wrap, cancel, invalid index
      do_step(1'b1, 1'b0, 1);
      check_word(freq_offset_out[3], 16'h0100);
      check_word(freq_offset_out[2], 16'h0000);
      step_output_sel_in = 4'h9;
      do_step(1'b0, 1'b1, 1);
      do_step(1'b0, 1'b1, 1);
      check_word(freq_offset_out[9], 16'hFE00);
      step_output_sel_in = 4'h3;
      step_size_in = 16'h0010;
      do_step(1'b1, 1'b1, 0);
      check_word(freq_offset_out[3], 16'h0100);
      step_output_sel_in = 4'hA;
      do_step(1'b1, 1'b0, 0);
      check_word(freq_offset_out[9], 16'hFE00);
      // Device reset pin in mid-run, then realignment
      cgcs_host_model_i.set_pins(5'b01101);
      tick(1);
      check_reset();
      cgcs_host_model_i.set_pins(5'b11101);
      tick(2);
      cgcs_host_model_i.realign();
      tick(2);
      check_bit(divider_reset_out, 1'b0);
      check_word(freq_offset_out[3], 16'h0000);
      report_and_stop();
   end
endmodule // cgcs_ctrl_tb
